// ---- shared/asr_pkg.sv ----
// Purpose: Shared constants for the asynchronous serial receiver
// Assumes: 8-bit register port, 3-bit word addresses
// Notes: Offsets are word indices on the plain register port

package asr_pkg;

  // ==========================================================
  // Register port
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] ADDR_RSC = 3'h0;
  localparam logic [2:0] ADDR_HOLD = 3'h1;
  localparam logic [2:0] ADDR_BAUD = 3'h2;
  localparam logic [2:0] ADDR_ISTAT = 3'h3;
  localparam logic [2:0] ADDR_IMASK = 3'h4;

  // ==========================================================
  // Status/control bit positions
  localparam int RSC_NINTH = 0;
  localparam int RSC_OVR = 1;
  localparam int RSC_FRAMING_ERROR_FLAG = 2;
  localparam int RSC_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RSC_READY = 5;
  localparam int RSC_NINE_EN = 6;

  // Interrupt status and mask bit positions
  localparam int INT_RX = 0;
  localparam int INT_OVR = 1;
  localparam int INT_FRAMING_ERROR_FLAG = 2;
  localparam int INT_W = 3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] BAUD_DIV_RST = 8'h00;
  localparam logic [2:0] INT_RST = 3'h0;

  // ==========================================================
  // Holding entry layout: data, ninth bit, framing error
  localparam int ENT_NINTH = 8;
  localparam int ENT_FRAMING_ERROR_FLAG = 9;
  localparam int ENT_W = 10;
  localparam int HOLD_DEPTH = 2;

  // ==========================================================
  // Oversampling: sub-bit index of the 7th, 8th, 9th edges
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SUB_FIRST = 4'h0;
  localparam logic [3:0] SUB_VOTE_A = 4'h6;
  localparam logic [3:0] SUB_VOTE_B = 4'h7;
  localparam logic [3:0] SUB_VOTE_C = 4'h8;
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;

  // Receiver states
  typedef enum logic [1:0] {
    ASR_IDLE = 2'b00,
    ASR_START = 2'b01,
    ASR_DATA = 2'b10,
    ASR_STOP = 2'b11
  } asr_state_e;

endpackage

// ---- verilog/asr_fifo.sv ----
// Purpose: Small shifting holding queue, head entry is a register
// Assumes: Push only offered while not full or while popping
// Notes: Entry 0 is always the oldest word

`timescale 1ns/100ps
`default_nettype none

module asr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Fill side
  input wire logic i_push,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  input wire logic i_pop,
  output logic [WIDTH-1:0] o_head,
  output logic o_empty,
  output logic o_full
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [CW-1:0] count;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] upper [DEPTH];

  // ==========================================================
  // Occupancy
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      count <= '0;
    end else if (i_push && !i_pop) begin
      count <= count + CW'(1);
    end else if (i_pop && !i_push && count != '0) begin
      count <= count - CW'(1);
    end
  end

  // Entries shift toward the head on a read
  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    if (g < DEPTH - 1) begin : g_up
      assign upper[g] = mem[g+1];
    end else begin : g_top
      assign upper[g] = '0;
    end
    always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
        mem[g] <= '0;
      end else if (i_pop) begin
        if (i_push && CW'(g + 1) == count) begin
          mem[g] <= i_data;
        end else begin
          mem[g] <= upper[g];
        end
      end else if (i_push && CW'(g) == count) begin
        mem[g] <= i_data;
      end
    end
  end

  assign o_head = mem[0];
  assign o_empty = (count == '0);
  assign o_full = (count == CW'(DEPTH));

  // Arrival order kept across a read
  a_fifo_order: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_pop && count > CW'(1) |=> o_head == $past(upper[0]))
    else $error("queue head is not the next older word");

endmodule // asr_fifo

`default_nettype wire

// ---- verilog/asr_receiver.sv ----
// Purpose: Asynchronous serial receiver with two-deep holding queue
// Assumes: Serial input synchronous to i_core_clk
// Notes: Byte frame is start, 8 or 9 data bits LSB first, stop
//
// Functional notes
// - Recovery shifter runs at sixteen times baud
// - Main shift register advances once per bit
// - Reception starts only after enable bit set
// - After stop, byte moves into queue
// - Ready flag set when byte transferred
// - Interrupt from ready only when enabled
// - Ready flag read-only, clears when queue empty
// - Queue holds two bytes, third shifts
// - Full queue at stop: overrun, byte lost
// - Two reads return bytes in order
// - Framing and ninth bit queued per byte
// - Each read exposes next entry's flags
// - Majority of samples on edges 7-9
//
// Our own choices: strobed register access and the placing of the registers.

`timescale 1ns/100ps
`default_nettype none

module asr_receiver #(
  parameter int DIV_W = 8,
  parameter int DEPTH = asr_pkg::HOLD_DEPTH
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Serial line
  input wire logic i_serial_input_pin,
  // Register port
  input wire logic [asr_pkg::ADDR_W-1:0] i_addr,
  input wire logic [asr_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [asr_pkg::DATA_W-1:0] o_rdata,
  // Status and interrupt
  output logic o_receive_ready_flag,
  output logic o_irq
);

  // ==========================================================
  // Declarations
  logic continuous_receive_enable;
  logic nine_bit_mode;
  logic overrun_error_flag;
  logic [DIV_W-1:0] baud_div;
  logic [DIV_W-1:0] div_cnt;
  logic tick;
  logic [asr_pkg::INT_W-1:0] int_stat;
  logic [asr_pkg::INT_W-1:0] int_mask;
  asr_pkg::asr_state_e state;
  logic [3:0] sub;
  logic [3:0] bit_cnt;
  logic [1:0] votes;
  logic voted;
  logic vote_now;
  logic [8:0] receive_shift_register;
  logic stop_done;
  logic push_ok;
  logic overrun_hit;
  logic [asr_pkg::ENT_W-1:0] push_data;
  logic [asr_pkg::ENT_W-1:0] head;
  logic fifo_empty;
  logic fifo_full;
  logic pop;
  logic wr_rsc;
  logic wr_istat;

  // ==========================================================
  // Register port decode
  assign wr_rsc = i_wr && (i_addr == asr_pkg::ADDR_RSC);
  assign wr_istat = i_wr && (i_addr == asr_pkg::ADDR_ISTAT);
  // Only a read of a non-empty queue advances it
  assign pop = i_rd && (i_addr == asr_pkg::ADDR_HOLD)
               && !fifo_empty;

  // Control bits of the status/control register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      continuous_receive_enable <= 1'b0;
      nine_bit_mode <= 1'b0;
    end else if (wr_rsc) begin
      continuous_receive_enable <= i_wdata[asr_pkg::RSC_CONTINUOUS_RECEIVE_ENABLE];
      nine_bit_mode <= i_wdata[asr_pkg::RSC_NINE_EN];
    end
  end

  // Baud divisor, sets the x16 tick period to div+1 clocks
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      baud_div <= DIV_W'(asr_pkg::BAUD_DIV_RST);
    end else if (i_wr && i_addr == asr_pkg::ADDR_BAUD) begin
      baud_div <= DIV_W'(i_wdata);
    end
  end

  // Interrupt mask; bit 0 is the receive interrupt enable
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      int_mask <= asr_pkg::INT_RST;
    end else if (i_wr && i_addr == asr_pkg::ADDR_IMASK) begin
      int_mask <= i_wdata[asr_pkg::INT_W-1:0];
    end
  end

  // ==========================================================
  // Free-running x16 tick while enabled
  assign tick = continuous_receive_enable && (div_cnt == '0);

  always_ff @(posedge i_core_clk) begin
    if (i_reset || !continuous_receive_enable) begin
      div_cnt <= '0;
    end else if (div_cnt == '0) begin
      div_cnt <= baud_div;
    end else begin
      div_cnt <= div_cnt - DIV_W'(1);
    end
  end

  // ==========================================================
  // Recovery shifter: two held samples plus the live third
  assign vote_now = tick && (sub == asr_pkg::SUB_VOTE_C)
                    && (state != asr_pkg::ASR_IDLE);
  // Two of three wins, so one noisy sample cannot flip a bit
  assign voted = (votes[1] & votes[0]) | (votes[1] & i_serial_input_pin)
                 | (votes[0] & i_serial_input_pin);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      votes <= 2'b00;
    end else if (tick && (sub == asr_pkg::SUB_VOTE_A
                          || sub == asr_pkg::SUB_VOTE_B)) begin
      votes <= {votes[0], i_serial_input_pin};
    end
  end

  // ==========================================================
  // Frame state machine, one sub-bit step per tick
  always_ff @(posedge i_core_clk) begin
    if (i_reset || !continuous_receive_enable) begin
      state <= asr_pkg::ASR_IDLE;
      sub <= asr_pkg::SUB_FIRST;
      bit_cnt <= '0;
    end else if (tick) begin
      case (state)
        asr_pkg::ASR_IDLE: begin
          // First low tick counts as edge one of the start bit
          if (!i_serial_input_pin) begin
            state <= asr_pkg::ASR_START;
            sub <= asr_pkg::SUB_FIRST + 4'h1;
          end
        end
        asr_pkg::ASR_START: begin
          sub <= sub + 4'h1;
          // A high vote means a glitch, not a start bit
          if (vote_now && voted) begin
            state <= asr_pkg::ASR_IDLE;
            sub <= asr_pkg::SUB_FIRST;
          end else if (sub == asr_pkg::SUB_LAST) begin
            state <= asr_pkg::ASR_DATA;
            bit_cnt <= '0;
          end
        end
        asr_pkg::ASR_DATA: begin
          sub <= sub + 4'h1;
          if (sub == asr_pkg::SUB_LAST) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt + 4'h1 == (nine_bit_mode ? asr_pkg::BITS_NINE
                                   : asr_pkg::BITS_EIGHT)) begin
              state <= asr_pkg::ASR_STOP;
            end
          end
        end
        asr_pkg::ASR_STOP: begin
          // Finish at the stop vote; the rest of the bit is idle
          sub <= sub + 4'h1;
          if (vote_now) begin
            state <= asr_pkg::ASR_IDLE;
            sub <= asr_pkg::SUB_FIRST;
          end
        end
        default: begin
          state <= asr_pkg::ASR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Main shift register, one step per bit period
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      receive_shift_register <= '0;
    end else if (vote_now && state == asr_pkg::ASR_DATA) begin
      receive_shift_register <= {voted, receive_shift_register[8:1]};
    end
  end

  // ==========================================================
  // Transfer to the holding queue at the stop vote
  assign stop_done = vote_now && (state == asr_pkg::ASR_STOP);
  // A read in the same cycle frees the slot in time
  assign push_ok = stop_done && (!fifo_full || pop);
  assign overrun_hit = stop_done && fifo_full && !pop;
  // Eight-bit frames land one place high in the shifter
  assign push_data = {!voted,
    nine_bit_mode ? receive_shift_register
                  : {1'b0, receive_shift_register[8:1]}};

  asr_fifo #(
    .WIDTH(asr_pkg::ENT_W),
    .DEPTH(DEPTH)
  ) u_hold (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_push(push_ok),
    .i_data(push_data),
    .i_pop(pop),
    .o_head(head),
    .o_empty(fifo_empty),
    .o_full(fifo_full)
  );

  // Overrun: sticky until enable is cleared, byte is dropped
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      overrun_error_flag <= 1'b0;
    end else if (overrun_hit) begin
      overrun_error_flag <= 1'b1;
    end else if (!continuous_receive_enable) begin
      overrun_error_flag <= 1'b0;
    end
  end

  // Ready flag follows queue occupancy; no write reaches it
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_receive_ready_flag <= 1'b0;
    end else begin
      o_receive_ready_flag <= !fifo_empty;
    end
  end

  // ==========================================================
  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      int_stat <= asr_pkg::INT_RST;
    end else begin
      int_stat <= (int_stat
                   & ~(wr_istat ? i_wdata[asr_pkg::INT_W-1:0]
                                : asr_pkg::INT_RST))
                  | {stop_done && !voted, overrun_hit, push_ok};
    end
  end

  // Masked request; receive events gated by enable bit
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(int_stat & int_mask);
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else if (!i_rd) begin
      o_rdata <= '0;
    end else if (i_addr == asr_pkg::ADDR_RSC) begin
      o_rdata <= '0;
      o_rdata[asr_pkg::RSC_NINTH] <= head[asr_pkg::ENT_NINTH];
      o_rdata[asr_pkg::RSC_OVR] <= overrun_error_flag;
      o_rdata[asr_pkg::RSC_FRAMING_ERROR_FLAG] <= head[asr_pkg::ENT_FRAMING_ERROR_FLAG];
      o_rdata[asr_pkg::RSC_CONTINUOUS_RECEIVE_ENABLE] <= continuous_receive_enable;
      o_rdata[asr_pkg::RSC_READY] <= o_receive_ready_flag;
      o_rdata[asr_pkg::RSC_NINE_EN] <= nine_bit_mode;
    end else if (i_addr == asr_pkg::ADDR_HOLD) begin
      o_rdata <= head[7:0];
    end else if (i_addr == asr_pkg::ADDR_BAUD) begin
      o_rdata <= 8'(baud_div);
    end else if (i_addr == asr_pkg::ADDR_ISTAT) begin
      o_rdata <= {5'h00, int_stat};
    end else if (i_addr == asr_pkg::ADDR_IMASK) begin
      o_rdata <= {5'h00, int_mask};
    end else begin
      o_rdata <= '0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  a_idle_when_off: assert property (
    !continuous_receive_enable |=> state == asr_pkg::ASR_IDLE)
    else $error("receiver active while enable is clear");

  a_overrun_set: assert property (
    overrun_hit |=> overrun_error_flag && $stable(fifo_full))
    else $error("overrun not flagged or queue changed");

  a_overrun_hold: assert property (
    overrun_error_flag && continuous_receive_enable
    |=> overrun_error_flag)
    else $error("overrun cleared while enabled");

  a_overrun_clear: assert property (
    !continuous_receive_enable && !overrun_hit
    |=> !overrun_error_flag)
    else $error("overrun survives disable");

  a_ready_rise: assert property (
    push_ok |=> ##1 o_receive_ready_flag)
    else $error("ready flag missing after transfer");

  // Last entry leaves with no refill, so the queue is empty
  a_ready_drop: assert property (
    pop && !push_ok && !fifo_full
    |=> ##1 !o_receive_ready_flag)
    else $error("ready flag held on empty queue");

  a_irq_gated: assert property (
    o_irq |-> $past(|(int_stat & int_mask)))
    else $error("interrupt without unmasked cause");

  // Ninth tick of the bit, whatever gap the divisor leaves
  a_vote_point: assert property (
    vote_now |-> ($past(sub) == asr_pkg::SUB_VOTE_B && $past(tick))
                 || ($past(sub) == asr_pkg::SUB_VOTE_C && !$past(tick)))
    else $error("vote taken off the ninth edge");

  a_shift_rate: assert property (
    !(vote_now && state == asr_pkg::ASR_DATA)
    |=> $stable(receive_shift_register))
    else $error("shift register moved between bit votes");

  a_framing_error_flag_entry: assert property (
    push_ok |-> push_data[asr_pkg::ENT_FRAMING_ERROR_FLAG] == !i_serial_input_pin
                || votes != {2{i_serial_input_pin}})
    else $error("framing flag disagrees with stop level");

endmodule // asr_receiver

`default_nettype wire

// ---- test/asr_tx_model.sv ----
// Purpose: Behavioural far-end transmitter driving the serial input pin
// Assumes: send is entered just after a rising clock edge
// Notes: Line idles high between frames, as a pulled-up line would

`timescale 1ns/100ps
`default_nettype none

module asr_tx_model (
  // Clock
  input wire logic i_core_clk,
  // Serial line
  output logic o_line
);
  // ==========================================================
  // Frame timing, set by the bench to match the divisor
  int bit_cycles = 16;

  // Idle level before the first frame
  initial o_line = 1'b1;

  // Start, data LSB first, optional ninth bit, stop of chosen level
  task automatic send(input logic [8:0] data, input logic nine,
                      input logic stop_lvl, input logic glitch);
    logic [10:0] bits;
    int n;
    bits = nine ? {stop_lvl, data, 1'b0} : {1'b1, stop_lvl, data[7:0], 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      o_line <= bits[i];
      repeat (7) @(posedge i_core_clk);
      // One-cycle spike on the middle sample only, when asked for
      if (glitch)
        o_line <= ~bits[i];
      @(posedge i_core_clk);
      o_line <= bits[i];
      repeat (bit_cycles - 8) @(posedge i_core_clk);
    end
    o_line <= 1'b1;
    @(posedge i_core_clk);
  endtask
endmodule // asr_tx_model

`default_nettype wire

// ---- test/tb_asr_receiver.sv ----
// Purpose: Self-checking bench for the asynchronous serial receiver
// Assumes: Divisor 0 gives sixteen clocks per bit
// Notes: Outputs are sampled at the falling edge, inputs change at rising

`timescale 1ns/100ps
`default_nettype none

module tb_asr_receiver;
  // ==========================================================
  // Status bit masks
  localparam logic [7:0] EN = 8'h01 << asr_pkg::RSC_CONTINUOUS_RECEIVE_ENABLE;
  localparam logic [7:0] NEN = 8'h01 << asr_pkg::RSC_NINE_EN;
  localparam logic [7:0] RDY = 8'h01 << asr_pkg::RSC_READY;
  localparam logic [7:0] OVR = 8'h01 << asr_pkg::RSC_OVR;
  localparam logic [7:0] FER = 8'h01 << asr_pkg::RSC_FRAMING_ERROR_FLAG;
  localparam logic [7:0] NIN = 8'h01 << asr_pkg::RSC_NINTH;

  logic i_core_clk;
  logic i_reset;
  logic line;
  logic i_wr;
  logic i_rd;
  logic [2:0] i_addr;
  logic [7:0] i_wdata;
  logic [7:0] o_rdata;
  logic o_receive_ready_flag;
  logic o_irq;
  int n_fail = 0;
  int comparisons = 0;

  asr_receiver #(.DIV_W(8), .DEPTH(2)) dut_u (
    .i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_serial_input_pin(line), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_receive_ready_flag(o_receive_ready_flag), .o_irq(o_irq)
  );

  asr_tx_model tx_u (.i_core_clk(i_core_clk), .o_line(line));

  // 250 MHz clock
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  // ==========================================================
  // Compare, bus and closing tasks
  task automatic chk8(input string what, input logic [7:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Flags are looked at mid-cycle, clear of the edge updates
  task automatic chk_flags(input logic exp_rdy, exp_irq);
    @(negedge i_core_clk);
    comparisons++;
    if ({o_receive_ready_flag, o_irq} !== {exp_rdy, exp_irq}) begin
      n_fail++;
      $display("unexpected flags: expected %b%b, seen %b%b", exp_rdy,
               exp_irq, o_receive_ready_flag, o_irq);
    end
    @(posedge i_core_clk);
  endtask

  // Extra edge at the end keeps strobes from being assigned twice
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    d = o_rdata;
    @(posedge i_core_clk);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] d;
    rd(asr_pkg::ADDR_RSC, d);
    chk8("status", 8'h00, d);
    rd(asr_pkg::ADDR_BAUD, d);
    chk8("divisor", asr_pkg::BAUD_DIV_RST, d);
    wr(3'h5, 8'hFF);
    rd(3'h5, d);
    chk8("unmapped", 8'h00, d);
    wr(asr_pkg::ADDR_RSC, RDY);
    rd(asr_pkg::ADDR_RSC, d);
    chk8("ready bit", 8'h00, d);
    chk_flags(1'b0, 1'b0);
    $display("test reset done");
  endtask

  // Nothing lands while the enable bit is clear
  task automatic t_disabled();
    logic [7:0] d;
    tx_u.send(9'h055, 1'b0, 1'b1, 1'b0);
    chk_flags(1'b0, 1'b0);
    rd(asr_pkg::ADDR_ISTAT, d);
    chk8("int status", 8'h00, d);
    wr(asr_pkg::ADDR_RSC, EN);
    $display("test disabled done");
  endtask

  // Two nine-bit bytes, second with a low stop bit
  task automatic t_order();
    logic [7:0] d;
    wr(asr_pkg::ADDR_RSC, EN | NEN);
    tx_u.send(9'h1A5, 1'b1, 1'b1, 1'b0);
    tx_u.send(9'h03C, 1'b1, 1'b0, 1'b0);
    chk_flags(1'b1, 1'b0);
    rd(asr_pkg::ADDR_RSC, d);
    chk8("status head", EN | NEN | RDY | NIN, d);
    rd(asr_pkg::ADDR_HOLD, d);
    chk8("first byte", 8'hA5, d);
    rd(asr_pkg::ADDR_RSC, d);
    chk8("status next", EN | NEN | RDY | FER, d);
    rd(asr_pkg::ADDR_HOLD, d);
    chk8("second byte", 8'h3C, d);
    chk_flags(1'b0, 1'b0);
    rd(asr_pkg::ADDR_ISTAT, d);
    chk8("int status", 8'h05, d);
    wr(asr_pkg::ADDR_RSC, EN);
    $display("test order done");
  endtask

  // Third byte meets a full queue
  task automatic t_overrun();
    logic [7:0] d;
    wr(asr_pkg::ADDR_ISTAT, 8'h07);
    tx_u.send(9'h011, 1'b0, 1'b1, 1'b0);
    tx_u.send(9'h022, 1'b0, 1'b1, 1'b0);
    tx_u.send(9'h033, 1'b0, 1'b1, 1'b0);
    rd(asr_pkg::ADDR_RSC, d);
    chk8("status full", EN | RDY | OVR, d);
    repeat (50) @(posedge i_core_clk);
    rd(asr_pkg::ADDR_RSC, d);
    chk8("status held", EN | RDY | OVR, d);
    rd(asr_pkg::ADDR_ISTAT, d);
    chk8("int status", 8'h03, d);
    rd(asr_pkg::ADDR_HOLD, d);
    chk8("kept first", 8'h11, d);
    rd(asr_pkg::ADDR_HOLD, d);
    chk8("kept second", 8'h22, d);
    chk_flags(1'b0, 1'b0);
    wr(asr_pkg::ADDR_RSC, 8'h00);
    rd(asr_pkg::ADDR_RSC, d);
    chk8("overrun off", 8'h00, d & OVR);
    wr(asr_pkg::ADDR_RSC, EN);
    $display("test overrun done");
  endtask

  // Interrupt follows the mask
  task automatic t_irq();
    logic [7:0] d;
    wr(asr_pkg::ADDR_ISTAT, 8'h07);
    tx_u.send(9'h081, 1'b0, 1'b1, 1'b0);
    chk_flags(1'b1, 1'b0);
    rd(asr_pkg::ADDR_ISTAT, d);
    chk8("int status", 8'h01, d);
    wr(asr_pkg::ADDR_IMASK, 8'h01);
    chk_flags(1'b1, 1'b1);
    wr(asr_pkg::ADDR_ISTAT, 8'h01);
    chk_flags(1'b1, 1'b0);
    wr(asr_pkg::ADDR_IMASK, 8'h00);
    rd(asr_pkg::ADDR_HOLD, d);
    chk8("byte", 8'h81, d);
    $display("test irq done");
  endtask

  // Spike on the middle sample of every bit is outvoted
  task automatic t_vote();
    logic [7:0] d;
    tx_u.send(9'h0C3, 1'b0, 1'b1, 1'b1);
    rd(asr_pkg::ADDR_HOLD, d);
    chk8("voted byte", 8'hC3, d);
    $display("test vote done");
  endtask

  // Divisor 1 doubles the bit time
  task automatic t_baud();
    logic [7:0] d;
    wr(asr_pkg::ADDR_BAUD, 8'h01);
    tx_u.bit_cycles = 32;
    tx_u.send(9'h096, 1'b0, 1'b1, 1'b0);
    rd(asr_pkg::ADDR_HOLD, d);
    chk8("slow byte", 8'h96, d);
    rd(asr_pkg::ADDR_BAUD, d);
    chk8("divisor", 8'h01, d);
    $display("test baud done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    i_reset = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    repeat (8) @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(posedge i_core_clk);
    t_reset();
    t_disabled();
    t_order();
    t_overrun();
    t_irq();
    t_vote();
    t_baud();
    conclude();
  end

  // Watchdog, about ten times the expected run
  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_fail++;
    $display("unexpected run length: expected end, seen watchdog");
    conclude();
  end
endmodule // tb_asr_receiver

`default_nettype wire
